// ---- common/matrix_pkg.sv ----
// Purpose: shared constants, types and address decode for the system bus matrix
// Assumes: one clock (mclk, 100 MHz), synchronous active-low reset
// Notes: the access table is indexed by slave, one bit per master
package matrix_pkg;
	localparam int NUM_MASTERS = 6;
	localparam int NUM_SLAVES = 9;
	typedef logic [2:0] master_id_t;
	typedef logic [3:0] slave_id_t;
	typedef logic [NUM_MASTERS-1:0] master_vec_t;

	// master numbering
	localparam master_id_t M_CPU_IDATA = 3'h0;
	localparam master_id_t M_CPU_SYSTEM = 3'h1;
	localparam master_id_t M_PERIPHERAL_DMA = 3'h2;
	localparam master_id_t M_USB_DMA = 3'h3;
	localparam master_id_t M_GENERAL_DMA = 3'h4;
	localparam master_id_t M_ETHERNET_DMA = 3'h5;

	// slave numbering
	localparam slave_id_t S_SRAM0 = 4'h0;
	localparam slave_id_t S_SRAM1 = 4'h1;
	localparam slave_id_t S_ROM = 4'h2;
	localparam slave_id_t S_FLASH = 4'h3;
	localparam slave_id_t S_USB_DUAL_PORT_RAM = 4'h4;
	localparam slave_id_t S_NAND_RAM = 4'h5;
	localparam slave_id_t S_EBI = 4'h6;
	localparam slave_id_t S_LOW_BRIDGE = 4'h7;
	localparam slave_id_t S_HIGH_BRIDGE = 4'h8;
	localparam slave_id_t S_NONE = 4'hf;

	// address map shared by all decoders, base and mask per slave
	localparam logic [31:0] SLAVE_BASE [NUM_SLAVES] = '{
		32'h2000_0000, 32'h2008_0000, 32'h0018_0000, 32'h0008_0000, 32'h2018_0000,
		32'h2010_0000, 32'h6000_0000, 32'h400e_0000, 32'h4000_0000};
	localparam logic [31:0] SLAVE_MASK [NUM_SLAVES] = '{
		32'hfff8_0000, 32'hfff8_0000, 32'hfff8_0000, 32'hfff8_0000, 32'hfff8_0000,
		32'hfff8_0000, 32'hf000_0000, 32'hfffe_0000, 32'hfff8_0000};

	// wired paths; bit m set means master m reaches that slave
	localparam master_vec_t ACCESS [NUM_SLAVES] = '{
		6'h3e, // sram0
		6'h3e, // sram1
		6'h3e, // rom
		6'h3d, // flash
		6'h01, // usb dual-port ram
		6'h12, // nand ram
		6'h3e, // ebi
		6'h3e, // low-speed bridge
		6'h16};// high-speed bridge

	// can clock divider
	localparam logic [1:0] CAN_DIV2_LAST = 2'h1;
	localparam logic [1:0] CAN_DIV4_LAST = 2'h3;

	typedef enum logic [1:0] {ARB_IDLE = 2'b01, ARB_OWNED = 2'b10} arb_state_t;

	// one decoder, copied per master, so every master sees the same map
	function automatic slave_id_t decode_slave(input logic [31:0] addr);
		slave_id_t hit;
		hit = S_NONE;
		for (int s = 0; s < NUM_SLAVES; s++) begin
			if ((addr & SLAVE_MASK[s]) == SLAVE_BASE[s]) begin
				hit = slave_id_t'(s);
			end
		end
		return hit;
	endfunction : decode_slave
endpackage : matrix_pkg

// ---- common/arb_if.sv ----
// Purpose: link between the matrix core and one slave arbiter
// Assumes: all signals in the mclk domain
// Notes: take and pick are combinational, owner registered, busy decoded from the registered state
`timescale 1ns/10ps
interface arb_if;
	import matrix_pkg::*;
	master_vec_t req;
	logic policy_fixed;
	logic done;
	logic take;
	master_id_t pick;
	master_id_t owner;
	logic busy;
	modport arbiter(input req, input policy_fixed, input done, output take, output pick, output owner, output busy);
	modport matrix(output req, output policy_fixed, output done, input take, input pick, input owner, input busy);
endinterface : arb_if

// ---- design/slave_arbiter.sv ----
// Purpose: per-slave arbiter, round robin or fixed priority
// Assumes: requests already filtered by decode and wired paths
// Notes: the slave stays owned until its ready is seen, so no split access
`timescale 1ns/10ps
module slave_arbiter
	import matrix_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// matrix side
	arb_if.arbiter port
);
	arb_state_t state;
	master_id_t last;
	logic found;
	int idx;
	int start;

	// search from the master after the last winner; fixed mode always starts at master 0
	always_comb begin
		found = 1'b0;
		idx = 0;
		start = port.policy_fixed ? (NUM_MASTERS - 1) : int'(last);
		port.pick = M_CPU_IDATA;
		for (int i = 1; i <= NUM_MASTERS; i++) begin
			idx = (start + i) % NUM_MASTERS;
			if (!found && port.req[idx]) begin
				found = 1'b1;
				port.pick = master_id_t'(idx);
			end
		end
	end

	assign port.take = (state == ARB_IDLE) && found;
	assign port.busy = (state == ARB_OWNED);

	// grant held until the slave answers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state <= ARB_IDLE;
			last <= M_ETHERNET_DMA;
			port.owner <= M_CPU_IDATA;
		end else begin
			unique case (state)
				ARB_IDLE: begin
					if (port.take) begin
						state <= ARB_OWNED;
						last <= port.pick;
						port.owner <= port.pick;
					end
				end
				ARB_OWNED: begin
					if (port.done) begin
						state <= ARB_IDLE;
					end
				end
			endcase
		end
	end
endmodule : slave_arbiter

// ---- design/system_bus_matrix.sv ----
// Purpose: six-master, nine-slave system bus matrix with per-master decode and per-slave arbitration
// Assumes: a master holds req, addr, write and wdata until it sees m_ready
// Notes: every output is registered; one outstanding access per master
`timescale 1ns/10ps
module system_bus_matrix
	import matrix_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// master ports
	input wire logic [NUM_MASTERS-1:0] m_req,
	input wire logic [NUM_MASTERS-1:0][31:0] m_addr,
	input wire logic [NUM_MASTERS-1:0] m_write,
	input wire logic [NUM_MASTERS-1:0][31:0] m_wdata,
	output logic [NUM_MASTERS-1:0] m_ready,
	output logic [NUM_MASTERS-1:0] m_error,
	output logic [NUM_MASTERS-1:0][31:0] m_rdata,
	// slave ports
	output logic [NUM_SLAVES-1:0] s_sel,
	output logic [NUM_SLAVES-1:0][31:0] s_addr,
	output logic [NUM_SLAVES-1:0] s_write,
	output logic [NUM_SLAVES-1:0][31:0] s_wdata,
	output logic [NUM_SLAVES-1:0][2:0] s_master,
	input wire logic [NUM_SLAVES-1:0] s_ready,
	input wire logic [NUM_SLAVES-1:0][31:0] s_rdata,
	// arbitration policy per slave, 1 = fixed priority
	input wire logic [NUM_SLAVES-1:0] arb_fixed,
	// can clock on the low-speed bridge, 0 = divide by 2, 1 = divide by 4
	input wire logic can_div_sel,
	output logic can_clk_en
);
	logic [NUM_MASTERS-1:0] busy_m;
	logic [1:0] can_cnt;
	slave_id_t dest [NUM_MASTERS];
	logic [NUM_MASTERS-1:0] path_ok;
	logic [NUM_MASTERS-1:0] pending;
	logic [NUM_MASTERS-1:0] bad_req;
	logic [NUM_SLAVES-1:0] take_v;
	master_id_t pick_v [NUM_SLAVES];
	master_id_t owner_v [NUM_SLAVES];
	logic [NUM_SLAVES-1:0] done_v;
	master_vec_t req_v [NUM_SLAVES];
	logic [NUM_MASTERS-1:0] start_m;
	logic [NUM_MASTERS-1:0] finish_m;
	logic [NUM_MASTERS-1:0][31:0] back_rdata;
	logic [1:0] can_last;

	// one decoder per master, all from the same map
	genvar m, s;
	generate
		for (m = 0; m < NUM_MASTERS; m++) begin : g_master
			assign dest[m] = decode_slave(m_addr[m]);
			// an address outside the map or on an unwired path is refused
			assign path_ok[m] = (dest[m] != S_NONE) && ACCESS[dest[m]][m];
			// masked while busy and in the answer cycle so a held req is not taken twice
			assign pending[m] = m_req[m] && !busy_m[m] && !m_ready[m];
			assign bad_req[m] = pending[m] && !path_ok[m];
		end
	endgenerate

	// one arbiter per slave; independent arbiters let masters run concurrently
	generate
		for (s = 0; s < NUM_SLAVES; s++) begin : g_slave
			arb_if link ();
			for (m = 0; m < NUM_MASTERS; m++) begin : g_req
				assign req_v[s][m] = pending[m] && path_ok[m] && (dest[m] == slave_id_t'(s));
			end
			assign link.req = req_v[s];
			assign link.policy_fixed = arb_fixed[s];
			assign link.done = done_v[s];
			assign take_v[s] = link.take;
			assign pick_v[s] = link.pick;
			assign owner_v[s] = link.owner;
			// owned state and s_sel rise and fall on the same edges, so busy qualifies ready
			assign done_v[s] = link.busy && s_ready[s];
			slave_arbiter u_arb (
				.mclk(mclk),
				.rst_n(rst_n),
				.port(link)
			);
		end
	endgenerate

	// route grants and answers back to the master they belong to
	always_comb begin
		start_m = '0;
		finish_m = '0;
		back_rdata = '0;
		for (int j = 0; j < NUM_SLAVES; j++) begin
			if (take_v[j]) begin
				start_m[pick_v[j]] = 1'b1;
			end
			if (done_v[j]) begin
				finish_m[owner_v[j]] = 1'b1;
				back_rdata[owner_v[j]] = s_rdata[j];
			end
		end
	end

	// slave side registers: request launched on grant, dropped on ready
	// both bridges are ordinary slaves with their own arbiter, so they run side by side
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_sel <= '0;
			s_addr <= '0;
			s_write <= '0;
			s_wdata <= '0;
			s_master <= '0;
		end else begin
			for (int j = 0; j < NUM_SLAVES; j++) begin
				if (take_v[j]) begin
					s_sel[j] <= 1'b1;
					s_addr[j] <= m_addr[pick_v[j]];
					s_write[j] <= m_write[pick_v[j]];
					s_wdata[j] <= m_wdata[pick_v[j]];
					s_master[j] <= pick_v[j];
				end else if (done_v[j]) begin
					s_sel[j] <= 1'b0;
				end
			end
		end
	end

	// master side registers: one-cycle ready, error only for refused requests
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			busy_m <= '0;
			m_ready <= '0;
			m_error <= '0;
			m_rdata <= '0;
		end else begin
			busy_m <= (busy_m | start_m) & ~finish_m;
			m_ready <= finish_m | bad_req;
			m_error <= bad_req;
			for (int k = 0; k < NUM_MASTERS; k++) begin
				if (finish_m[k]) begin
					m_rdata[k] <= back_rdata[k];
				end
			end
		end
	end

	// can clock enable for the low-speed bridge; high-speed bridge peripherals use mclk as is
	// an enable pulse rather than a derived clock keeps the design in one domain
	assign can_last = can_div_sel ? CAN_DIV4_LAST : CAN_DIV2_LAST;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			can_cnt <= '0;
			can_clk_en <= 1'b0;
		end else begin
			can_cnt <= (can_cnt >= can_last) ? 2'h0 : can_cnt + 2'h1;
			can_clk_en <= (can_cnt >= can_last);
		end
	end
	// peripherals themselves (spi, serial port, memory card on the high bridge; cans and
	// the rest on the low bridge) live outside, selected by the bridge address windows
endmodule : system_bus_matrix

// ---- testbench/matrix_chk.sv ----
// Purpose: port-level checks of the system bus matrix
// Assumes: one clock domain, mclk, with synchronous active-low rst_n
// Notes: wired paths are judged against the shared access table
`timescale 1ns/10ps
module matrix_chk
	import matrix_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// master side answers
	input wire logic [NUM_MASTERS-1:0] m_ready,
	input wire logic [NUM_MASTERS-1:0] m_error,
	// slave side
	input wire logic [NUM_SLAVES-1:0] s_sel,
	input wire logic [NUM_SLAVES-1:0][31:0] s_addr,
	input wire logic [NUM_SLAVES-1:0][2:0] s_master,
	input wire logic [NUM_SLAVES-1:0] s_ready,
	// can divider
	input wire logic can_div_sel,
	input wire logic can_clk_en
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// a refusal always comes as a finished access, never as a hang
	AST_ERR_READY: assert property ((m_error & ~m_ready) == '0) else $error("error without ready");
	AST_READY_PULSE: assert property (m_ready != '0 |=> (m_ready & $past(m_ready)) == '0) else $error("ready held");
	AST_USB_PATH: assert property (s_sel[4] |-> s_master[4] == 3'h0) else $error("usb ram owner");
	AST_NAND_PATH: assert property (s_sel[5] |-> s_master[5] inside {3'h1, 3'h4}) else $error("nand owner");
	AST_HIGH_PATH: assert property (s_sel[8] |-> s_master[8] inside {3'h1, 3'h2, 3'h4}) else $error("bridge owner");
	AST_CAN_GAP: assert property (can_clk_en |=> !can_clk_en) else $error("can enable held");
	AST_CAN_DIV2: assert property (can_clk_en && !can_div_sel ##1 !can_div_sel |=> can_clk_en) else $error("div2");
	AST_CAN_DIV4: assert property (can_clk_en && can_div_sel ##1 can_div_sel [*3] |=> can_clk_en) else $error("div4");
	// per slave: owner must be wired, access held until ready, then answered
	for (genvar s = 0; s < NUM_SLAVES; s++) begin : g_slave
		AST_WIRED: assert property (s_sel[s] |-> ACCESS[s][s_master[s]]) else $error("unwired owner");
		AST_SEL_HOLD: assert property (s_sel[s] && !s_ready[s] |=> s_sel[s] && $stable(s_addr[s])) else $error("hold");
		AST_DONE: assert property (s_sel[s] && s_ready[s] |=> !s_sel[s] && m_ready[$past(s_master[s])]) else $error("done");
	end
endmodule : matrix_chk
bind system_bus_matrix matrix_chk i_chk (.mclk(mclk), .rst_n(rst_n), .m_ready(m_ready), .m_error(m_error),
	.s_sel(s_sel), .s_addr(s_addr), .s_master(s_master), .s_ready(s_ready), .can_div_sel(can_div_sel),
	.can_clk_en(can_clk_en));

// ---- testbench/slave_model.sv ----
// Purpose: behavioural slaves behind the nine matrix slave ports
// Assumes: a slave answers only while it is selected
// Notes: slaves stall 0 to 2 cycles so owned slaves and waiting masters occur
`timescale 1ns/10ps
module slave_model
	import matrix_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// slave ports
	input wire logic [NUM_SLAVES-1:0] s_sel,
	input wire logic [NUM_SLAVES-1:0][31:0] s_addr,
	output logic [NUM_SLAVES-1:0] s_ready,
	output logic [NUM_SLAVES-1:0][31:0] s_rdata
);
	logic [1:0] wait_cnt [NUM_SLAVES];
	// slave s waits s mod 3 cycles; data is a fixed scramble of the address
	for (genvar s = 0; s < NUM_SLAVES; s++) begin : g_s
		assign s_ready[s] = s_sel[s] && wait_cnt[s] == 2'(s % 3);
		// off-cycle data is inverted so that a stale sample never matches
		assign s_rdata[s] = s_ready[s] ? s_addr[s] ^ 32'h5a5a_5a5a : ~(s_addr[s] ^ 32'h5a5a_5a5a);
		always_ff @(posedge mclk) begin
			wait_cnt[s] <= (!rst_n || !s_sel[s] || s_ready[s]) ? 2'h0 : wait_cnt[s] + 2'h1;
		end
	end
endmodule : slave_model

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench for the system bus matrix
// Assumes: masters read and write; inputs change at the falling edge
// Notes: masters drop req in their ready cycle, which also logs time and error
`timescale 1ns/10ps
module tb_top
	import matrix_pkg::*;
;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [NUM_MASTERS-1:0] m_req = '0;
	logic [NUM_MASTERS-1:0] m_write = '0;
	logic [NUM_MASTERS-1:0][31:0] m_addr = '0;
	logic [NUM_MASTERS-1:0][31:0] m_wdata = '0;
	logic [NUM_MASTERS-1:0] m_ready, m_error, err_seen;
	logic [NUM_MASTERS-1:0][31:0] m_rdata;
	logic [NUM_SLAVES-1:0] s_sel, s_write, s_ready;
	logic [NUM_SLAVES-1:0] arb_fixed = '0;
	logic [NUM_SLAVES-1:0][31:0] s_addr, s_wdata, s_rdata;
	logic [NUM_SLAVES-1:0][2:0] s_master;
	logic can_div_sel = 1'b0;
	logic can_clk_en;
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;
	int done_at [NUM_MASTERS];
	always #5 mclk = ~mclk;
	system_bus_matrix i_dut (.mclk(mclk), .rst_n(rst_n), .m_req(m_req), .m_addr(m_addr), .m_write(m_write),
		.m_wdata(m_wdata), .m_ready(m_ready), .m_error(m_error), .m_rdata(m_rdata), .s_sel(s_sel), .s_addr(s_addr),
		.s_write(s_write), .s_wdata(s_wdata), .s_master(s_master), .s_ready(s_ready), .s_rdata(s_rdata),
		.arb_fixed(arb_fixed), .can_div_sel(can_div_sel), .can_clk_en(can_clk_en));
	slave_model i_slaves (.mclk(mclk), .rst_n(rst_n), .s_sel(s_sel), .s_addr(s_addr), .s_ready(s_ready),
		.s_rdata(s_rdata));
	// ready seen: release the request and keep error flag and finish time
	always @(negedge mclk) begin
		for (int i = 0; i < NUM_MASTERS; i++) begin
			if (m_ready[i] === 1'b1) begin
				m_req[i] <= 1'b0;
				err_seen[i] <= m_error[i];
				done_at[i] <= cyc;
			end
		end
	end
	// the cycle count doubles as the hang limit
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic put(input int m, input logic [31:0] a);
		m_addr[m] = a;
		m_wdata[m] = ~a;
	endtask : put
	// raise the given requests together, wait a bounded time for all answers
	task automatic go(input logic [NUM_MASTERS-1:0] mask);
		int n;
		m_req = m_req | mask;
		n = 0;
		while ((m_req & mask) != '0 && n < 60) begin
			@(posedge mclk);
			n++;
		end
		chk("answer", 32'h0, 32'(m_req & mask));
	endtask : go
	// every master against every slave, plus a hole in the map
	task automatic t_map();
		logic [31:0] a;
		for (int m = 0; m < NUM_MASTERS; m++) begin
			for (int s = 0; s <= NUM_SLAVES; s++) begin
				a = (s == NUM_SLAVES) ? 32'h1000_0000 : SLAVE_BASE[s] + 32'(4 * m);
				@(negedge mclk);
				put(m, a);
				m_write[m] = s[0];
				go(6'(1 << m));
				chk("error", 32'((s == NUM_SLAVES) || !ACCESS[s][m]), 32'(err_seen[m]));
				if (s < NUM_SLAVES && ACCESS[s][m]) begin
					chk("rdata", a ^ 32'h5a5a_5a5a, m_rdata[m]);
					chk("write", 32'(s[0]), 32'(s_write[s]));
					chk("wdata", ~a, s_wdata[s]);
				end
			end
		end
	endtask : t_map
	// five masters on five slaves at once, both bridges among them
	task automatic t_conc();
		int t0;
		@(negedge mclk);
		put(0, SLAVE_BASE[3]);
		put(1, SLAVE_BASE[7]);
		put(2, SLAVE_BASE[8]);
		put(4, SLAVE_BASE[5]);
		put(5, SLAVE_BASE[1]);
		t0 = cyc;
		go(6'h37);
		for (int i = 0; i < NUM_MASTERS; i++) begin
			if (i != 3) begin
				chk("rdata", m_addr[i] ^ 32'h5a5a_5a5a, m_rdata[i]);
				chk("parallel", 32'h1, 32'(done_at[i] - t0 <= 6));
			end
		end
	endtask : t_conc
	// contention: fixed priority on one slave, round robin on another
	task automatic t_arb();
		@(negedge mclk);
		arb_fixed = 9'h001;
		// m1 wins alone first, so round robin would favour m3 next and only fixed priority keeps m1 ahead
		put(1, SLAVE_BASE[0]);
		go(6'h02);
		@(negedge mclk);
		put(3, SLAVE_BASE[0]);
		put(1, SLAVE_BASE[0] + 32'h10);
		go(6'h0a);
		chk("fixed order", 32'h1, 32'(done_at[1] < done_at[3]));
		@(negedge mclk);
		put(1, SLAVE_BASE[1]);
		go(6'h02);
		@(negedge mclk);
		put(3, SLAVE_BASE[1] + 32'h10);
		go(6'h0a);
		chk("round robin", 32'h1, 32'(done_at[3] < done_at[1]));
	endtask : t_arb
	// mid-run reset cuts an owned access; outputs go to zero and traffic resumes afterwards
	task automatic t_reset();
		@(negedge mclk);
		put(2, SLAVE_BASE[8]);
		m_req[2] = 1'b1;
		@(negedge mclk);
		rst_n = 1'b0;
		m_req[2] = 1'b0;
		repeat (2) @(negedge mclk);
		chk("reset sel", 32'h0, 32'(s_sel));
		chk("reset ready", 32'h0, 32'(m_ready));
		chk("reset can", 32'h0, 32'(can_clk_en));
		rst_n = 1'b1;
		@(negedge mclk);
		put(2, SLAVE_BASE[8]);
		go(6'h04);
		chk("rdata", SLAVE_BASE[8] ^ 32'h5a5a_5a5a, m_rdata[2]);
	endtask : t_reset
	// count divider pulses over 16 cycles in both settings
	task automatic t_can();
		int n;
		for (int d = 0; d < 2; d++) begin
			@(negedge mclk);
			can_div_sel = d[0];
			repeat (8) @(negedge mclk);
			n = 0;
			repeat (16) begin
				@(negedge mclk);
				n += int'(can_clk_en === 1'b1);
			end
			chk("can pulses", d ? 32'h4 : 32'h8, 32'(n));
		end
	endtask : t_can
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (5) @(negedge mclk);
		chk("reset ready", 32'h0, 32'(m_ready));
		rst_n = 1'b1;
		t_map();
		t_conc();
		t_arb();
		t_reset();
		t_can();
		summarize();
	end
endmodule : tb_top
